/* File: hdl/rbm_cfg.svh */
`ifndef RBM_CFG_SVH
`define RBM_CFG_SVH

// buffer address width and pointer arithmetic
`define RBM_AW        13
`define RBM_PTR_RST   13'h0000
`define RBM_STEP_ONE  13'h0001
`define RBM_HDR_LEN   13'h0006
`define RBM_SIZE_ONE  14'h0001

// packet counter
`define RBM_PKT_MAX   8'hff
`define RBM_PKT_ZERO  8'h00
`define RBM_PKT_ONE   8'h01

// largest value of a type/length field that is still a length
`define RBM_TYPE_MAX  16'h05dc
`define RBM_CNT_ONE   16'h0001
`define RBM_CNT_RST   16'h0000

// header byte index of the last header byte
`define RBM_HDR_LAST  3'h5

// receive status vector bit positions
`define RBM_SB_ZERO   31
`define RBM_SB_VLAN   30
`define RBM_SB_UNKOP  29
`define RBM_SB_PAUSE  28
`define RBM_SB_CTRL   27
`define RBM_SB_DRIB   26
`define RBM_SB_BCAST  25
`define RBM_SB_MCAST  24
`define RBM_SB_OK     23
`define RBM_SB_LOOR   22
`define RBM_SB_LCHK   21
`define RBM_SB_CRC    20
`define RBM_SB_RES19  19
`define RBM_SB_CARR   18
`define RBM_SB_RES17  17
`define RBM_SB_LONG   16
`define RBM_SB_CNT_HI 15

// link flag vector width and width of the whole sampled link word
`define RBM_FLAG_W    28
`define RBM_LINK_W    38

`endif

/* File: hdl/rbm_pkg.sv */
`include "rbm_cfg.svh"

package rbm_pkg;

   typedef logic [`RBM_AW-1:0] rbm_addr_t;

   typedef enum logic [1:0] {
      RBM_IDLE = 2'b00,
      RBM_DATA = 2'b01,
      RBM_HDR  = 2'b10,
      RBM_DROP = 2'b11
   } rbm_state_e;

   // per-frame classification supplied by the mac, stable at frame end
   typedef struct packed {
      logic        vlan;
      logic        unknown_op;
      logic        pause_ok;
      logic        ctrl;
      logic        dribble;
      logic        bcast;
      logic        mcast;
      logic        crc_err;
      logic        symbol_err;
      logic        len_mismatch;
      logic        long_event;
      logic        carrier_event;
      logic [15:0] type_len;
   } rbm_flags_s;

endpackage

/* File: hdl/rbm_link_if.sv */
`timescale 1ns/100ps
`include "rbm_cfg.svh"

interface rbm_link_if;
   logic                byte_stb;
   logic                frame_start;
   logic                frame_end;
   logic [7:0]          data;
   rbm_pkg::rbm_flags_s flags;

   modport src (output byte_stb, output frame_start, output frame_end,
                output data, output flags);
   modport dst (input byte_stb, input frame_start, input frame_end,
                input data, input flags);
endinterface

/* File: hdl/rbm_link_sync.sv */
`timescale 1ns/100ps
`include "rbm_cfg.svh"

module rbm_link_sync (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic                   link_clk,
   input  wire logic                   link_valid,
   input  wire logic [7:0]             link_data,
   input  wire logic [`RBM_FLAG_W-1:0] link_flags,
   rbm_link_if.src                     lnk
);
   logic [`RBM_LINK_W-1:0] meta;
   logic [`RBM_LINK_W-1:0] samp;
   logic                   clk_prev;
   logic                   valid_prev;
   logic [`RBM_LINK_W-1:0] next_meta;
   logic [`RBM_LINK_W-1:0] next_samp;
   logic                   next_clk_prev;
   logic                   next_valid_prev;

   // meta feeds only samp; all edge detection looks at samp
   always_comb begin
      next_meta       = {link_clk, link_valid, link_data, link_flags};
      next_samp       = meta;
      next_clk_prev   = samp[`RBM_LINK_W-1];
      next_valid_prev = samp[`RBM_LINK_W-2];
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta       <= '0;
         samp       <= '0;
         clk_prev   <= 1'b0;
         valid_prev <= 1'b0;
      end else begin
         meta       <= next_meta;
         samp       <= next_samp;
         clk_prev   <= next_clk_prev;
         valid_prev <= next_valid_prev;
      end
   end

   // the sender changes data on the falling link edge, so it is settled at the rising one
   assign lnk.byte_stb    = samp[`RBM_LINK_W-1] & ~clk_prev & samp[`RBM_LINK_W-2];
   assign lnk.frame_start = samp[`RBM_LINK_W-2] & ~valid_prev;
   assign lnk.frame_end   = ~samp[`RBM_LINK_W-2] & valid_prev;
   assign lnk.data        = samp[`RBM_FLAG_W+7:`RBM_FLAG_W];
   assign lnk.flags       = rbm_pkg::rbm_flags_s'(samp[`RBM_FLAG_W-1:0]);
endmodule

/* File: hdl/rbm_ring_manager.sv */
`timescale 1ns/100ps
`include "rbm_cfg.svh"

module rbm_ring_manager (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic                   link_clk,
   input  wire logic                   link_valid,
   input  wire logic [7:0]             link_data,
   input  wire logic [`RBM_FLAG_W-1:0] link_flags,
   input  wire logic                   rx_enable,
   input  wire logic [`RBM_AW-1:0]     rx_ring_start,
   input  wire logic [`RBM_AW-1:0]     rx_ring_end,
   input  wire logic                   pointer_auto_advance,
   input  wire logic                   buffer_read_command,
   input  wire logic                   buffer_read_pointer_wr,
   input  wire logic [`RBM_AW-1:0]     buffer_read_pointer_wdata,
   input  wire logic                   rx_release_pointer_low_wr,
   input  wire logic                   rx_release_pointer_high_wr,
   input  wire logic [7:0]             rx_release_wdata,
   input  wire logic                   packet_decrement_cmd,
   input  wire logic                   rx_error_clear,
   input  wire logic                   rx_error_int_enable,
   input  wire logic                   packet_int_enable,
   input  wire logic [7:0]             mem_rd_data,
   output logic [`RBM_AW-1:0]          mem_rd_addr,
   output logic                        mem_we,
   output logic [`RBM_AW-1:0]          mem_wr_addr,
   output logic [7:0]                  mem_wr_data,
   output logic [7:0]                  buffer_read_data,
   output logic [`RBM_AW-1:0]          buffer_read_pointer,
   output logic [7:0]                  rx_release_pointer_low,
   output logic [7:0]                  rx_release_pointer_high,
   output logic [`RBM_AW-1:0]          rx_hw_write_pointer,
   output logic [7:0]                  pending_packet_count,
   output logic                        packet_pending_flag,
   output logic                        rx_error_flag,
   output logic                        irq
);
   rbm_link_if lnk ();

   rbm_link_sync u_sync (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .link_clk   (link_clk),
      .link_valid (link_valid),
      .link_data  (link_data),
      .link_flags (link_flags),
      .lnk        (lnk.src)
   );

   // ring addition with wrap from end back to start
   function automatic rbm_pkg::rbm_addr_t wrap_add(input rbm_pkg::rbm_addr_t p,
                                                   input rbm_pkg::rbm_addr_t n);
      logic [`RBM_AW:0] s;
      logic [`RBM_AW:0] sz;
      s  = {1'b0, p} + {1'b0, n};
      sz = {1'b0, rx_ring_end} - {1'b0, rx_ring_start} + `RBM_SIZE_ONE;
      if (s > {1'b0, rx_ring_end}) begin
         s = s - sz;
      end
      return s[`RBM_AW-1:0];
   endfunction

   // free bytes from write pointer up to release pointer; equal means empty
   function automatic logic [`RBM_AW:0] ring_gap(input rbm_pkg::rbm_addr_t w,
                                                 input rbm_pkg::rbm_addr_t r);
      logic [`RBM_AW:0] d;
      d = {1'b0, r} - {1'b0, w};
      if (r <= w) begin
         d = d + {1'b0, rx_ring_end} - {1'b0, rx_ring_start} + `RBM_SIZE_ONE;
      end
      return d;
   endfunction

   // ---------------- receive write engine ----------------
   rbm_pkg::rbm_state_e state;
   rbm_pkg::rbm_state_e next_state;
   rbm_pkg::rbm_addr_t  wr_ptr;
   rbm_pkg::rbm_addr_t  next_wr_ptr;
   rbm_pkg::rbm_addr_t  cur;
   rbm_pkg::rbm_addr_t  next_cur;
   rbm_pkg::rbm_addr_t  nxt_pkt;
   rbm_pkg::rbm_addr_t  next_nxt_pkt;
   logic [15:0]         byte_cnt;
   logic [15:0]         next_byte_cnt;
   rbm_pkg::rbm_flags_s flags;
   rbm_pkg::rbm_flags_s next_flags;
   logic [2:0]          hdr_idx;
   logic [2:0]          next_hdr_idx;
   logic                drop_seen;
   logic                next_drop_seen;
   logic                next_mem_we;
   rbm_pkg::rbm_addr_t  next_mem_wr_addr;
   logic [7:0]          next_mem_wr_data;
   logic                commit;
   logic                err_set;
   logic [31:0]         status;
   rbm_pkg::rbm_addr_t  rel_ptr;
   rbm_pkg::rbm_addr_t  pad_ptr;

   always_comb begin
      status                 = '0;
      status[`RBM_SB_VLAN]   = flags.vlan;
      status[`RBM_SB_UNKOP]  = flags.ctrl & flags.unknown_op;
      status[`RBM_SB_PAUSE]  = flags.ctrl & flags.pause_ok;
      status[`RBM_SB_CTRL]   = flags.ctrl;
      status[`RBM_SB_DRIB]   = flags.dribble;
      status[`RBM_SB_BCAST]  = flags.bcast;
      status[`RBM_SB_MCAST]  = flags.mcast;
      status[`RBM_SB_OK]     = ~flags.crc_err & ~flags.symbol_err;
      status[`RBM_SB_LOOR]   = flags.type_len > `RBM_TYPE_MAX;
      status[`RBM_SB_LCHK]   = flags.len_mismatch &
                               (flags.type_len <= `RBM_TYPE_MAX);
      status[`RBM_SB_CRC]    = flags.crc_err;
      status[`RBM_SB_CARR]   = flags.carrier_event;
      status[`RBM_SB_LONG]   = flags.long_event | drop_seen;
      status[`RBM_SB_CNT_HI:0] = byte_cnt;
   end

   always_comb begin
      next_state       = state;
      next_wr_ptr      = wr_ptr;
      next_cur         = cur;
      next_nxt_pkt     = nxt_pkt;
      next_byte_cnt    = byte_cnt;
      next_flags       = flags;
      next_hdr_idx     = hdr_idx;
      next_drop_seen   = drop_seen;
      next_mem_we      = 1'b0;
      next_mem_wr_addr = mem_wr_addr;
      next_mem_wr_data = mem_wr_data;
      commit           = 1'b0;
      err_set          = 1'b0;
      pad_ptr          = cur;
      unique case (state)
         rbm_pkg::RBM_IDLE: begin
            if (!rx_enable) begin
               next_wr_ptr = rx_ring_start;
            end else if (lnk.frame_start) begin
               // header space is reserved up front so it can never land on the release slot
               if (pending_packet_count == `RBM_PKT_MAX ||
                   ring_gap(wr_ptr, rel_ptr) <= {1'b0, `RBM_HDR_LEN}) begin
                  err_set        = 1'b1;
                  next_drop_seen = 1'b1;
                  next_state     = rbm_pkg::RBM_DROP;
               end else begin
                  next_cur      = wrap_add(wr_ptr, `RBM_HDR_LEN);
                  next_byte_cnt = `RBM_CNT_RST;
                  next_state    = rbm_pkg::RBM_DATA;
               end
            end
         end
         rbm_pkg::RBM_DATA: begin
            if (lnk.byte_stb) begin
               if (cur == rel_ptr) begin
                  err_set        = 1'b1;
                  next_drop_seen = 1'b1;
                  next_state     = rbm_pkg::RBM_DROP;
               end else begin
                  next_mem_we      = 1'b1;
                  next_mem_wr_addr = cur;
                  next_mem_wr_data = lnk.data;
                  next_cur         = wrap_add(cur, `RBM_STEP_ONE);
                  next_byte_cnt    = byte_cnt + `RBM_CNT_ONE;
               end
            end else if (lnk.frame_end) begin
               next_flags = lnk.flags;
               // an odd next slot means the last byte sat on an even-odd pair start
               pad_ptr = cur[0] ? wrap_add(cur, `RBM_STEP_ONE) : cur;
               // the write pointer may never reach the release pointer
               if (pad_ptr == rel_ptr) begin
                  err_set        = 1'b1;
                  next_drop_seen = 1'b1;
                  next_state     = rbm_pkg::RBM_IDLE;
               end else begin
                  next_nxt_pkt = pad_ptr;
                  next_hdr_idx = '0;
                  next_state   = rbm_pkg::RBM_HDR;
               end
            end
         end
         rbm_pkg::RBM_HDR: begin
            next_mem_we      = 1'b1;
            next_mem_wr_addr = wrap_add(wr_ptr, {10'h000, hdr_idx});
            unique case (hdr_idx)
               3'h0:    next_mem_wr_data = nxt_pkt[7:0];
               3'h1:    next_mem_wr_data = {3'h0, nxt_pkt[`RBM_AW-1:8]};
               3'h2:    next_mem_wr_data = status[7:0];
               3'h3:    next_mem_wr_data = status[15:8];
               3'h4:    next_mem_wr_data = status[23:16];
               default: next_mem_wr_data = status[31:24];
            endcase
            next_hdr_idx = hdr_idx + 3'h1;
            if (hdr_idx == `RBM_HDR_LAST) begin
               commit         = 1'b1;
               next_wr_ptr    = nxt_pkt;
               next_drop_seen = 1'b0;
               next_state     = rbm_pkg::RBM_IDLE;
            end
         end
         rbm_pkg::RBM_DROP: begin
            // trailing bytes of an aborted frame are swallowed here
            if (lnk.frame_end) begin
               next_state = rbm_pkg::RBM_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state       <= rbm_pkg::RBM_IDLE;
         wr_ptr      <= `RBM_PTR_RST;
         cur         <= `RBM_PTR_RST;
         nxt_pkt     <= `RBM_PTR_RST;
         byte_cnt    <= `RBM_CNT_RST;
         flags       <= '0;
         hdr_idx     <= '0;
         drop_seen   <= 1'b0;
         mem_we      <= 1'b0;
         mem_wr_addr <= `RBM_PTR_RST;
         mem_wr_data <= 8'h00;
      end else begin
         state       <= next_state;
         wr_ptr      <= next_wr_ptr;
         cur         <= next_cur;
         nxt_pkt     <= next_nxt_pkt;
         byte_cnt    <= next_byte_cnt;
         flags       <= next_flags;
         hdr_idx     <= next_hdr_idx;
         drop_seen   <= next_drop_seen;
         mem_we      <= next_mem_we;
         mem_wr_addr <= next_mem_wr_addr;
         mem_wr_data <= next_mem_wr_data;
      end
   end

   // ---------------- host-facing state ----------------
   rbm_pkg::rbm_addr_t next_rel_ptr;
   logic [7:0]         rel_hold;
   logic [7:0]         next_rel_hold;
   rbm_pkg::rbm_addr_t rd_ptr;
   rbm_pkg::rbm_addr_t next_rd_ptr;
   logic [7:0]         next_rd_data;
   logic [7:0]         next_count;
   logic               next_pkt_flag;
   logic               next_err;
   logic               dec_ok;

   always_comb begin
      next_rel_ptr  = rel_ptr;
      next_rel_hold = rel_hold;
      next_rd_ptr   = rd_ptr;
      next_rd_data  = buffer_read_data;
      next_count    = pending_packet_count;
      next_pkt_flag = packet_pending_flag;
      next_err      = rx_error_flag;
      dec_ok        = packet_decrement_cmd &&
                      pending_packet_count != `RBM_PKT_ZERO;
      if (rx_release_pointer_low_wr) begin
         next_rel_hold = rx_release_wdata;
      end
      if (rx_release_pointer_high_wr) begin
         next_rel_ptr = {rx_release_wdata[`RBM_AW-9:0], rel_hold};
      end
      if (buffer_read_pointer_wr) begin
         next_rd_ptr = buffer_read_pointer_wdata;
      end else if (buffer_read_command) begin
         next_rd_data = mem_rd_data;
         if (pointer_auto_advance) begin
            next_rd_ptr = wrap_add(rd_ptr, `RBM_STEP_ONE);
         end
      end
      // a store and a decrement in one cycle cancel, and the flag stays up
      if (commit && !dec_ok) begin
         next_count    = pending_packet_count + `RBM_PKT_ONE;
         next_pkt_flag = 1'b1;
      end else if (dec_ok && !commit) begin
         next_count = pending_packet_count - `RBM_PKT_ONE;
         if (pending_packet_count == `RBM_PKT_ONE) begin
            next_pkt_flag = 1'b0;
         end
      end else if (commit) begin
         next_pkt_flag = 1'b1;
      end
      if (err_set) begin
         next_err = 1'b1;
      end else if (rx_error_clear) begin
         next_err = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rel_ptr              <= `RBM_PTR_RST;
         rel_hold             <= 8'h00;
         rd_ptr               <= `RBM_PTR_RST;
         buffer_read_data     <= 8'h00;
         pending_packet_count <= `RBM_PKT_ZERO;
         packet_pending_flag  <= 1'b0;
         rx_error_flag        <= 1'b0;
      end else begin
         rel_ptr              <= next_rel_ptr;
         rel_hold             <= next_rel_hold;
         rd_ptr               <= next_rd_ptr;
         buffer_read_data     <= next_rd_data;
         pending_packet_count <= next_count;
         packet_pending_flag  <= next_pkt_flag;
         rx_error_flag        <= next_err;
      end
   end

   // the holding byte reaches an output only through rel_ptr, on a high-byte write
   assign rx_release_pointer_low  = rel_ptr[7:0];
   assign rx_release_pointer_high = {3'h0, rel_ptr[`RBM_AW-1:8]};
   assign buffer_read_pointer     = rd_ptr;
   assign mem_rd_addr             = rd_ptr;
   assign rx_hw_write_pointer     = wr_ptr;
   assign irq = (rx_error_flag & rx_error_int_enable) |
                (packet_pending_flag & packet_int_enable);
endmodule

/* File: tb/rbm_sram_model.sv */
`timescale 1ns/100ps
module rbm_sram_model (
   input  wire logic        ref_clk,
   input  wire logic        mem_we,
   input  wire logic [12:0] mem_wr_addr,
   input  wire logic [7:0]  mem_wr_data,
   input  wire logic [12:0] mem_rd_addr,
   output logic      [7:0]  mem_rd_data
);
   logic [7:0] ram [0:8191];
   always_ff @(posedge ref_clk) begin
      if (mem_we) ram[mem_wr_addr] <= mem_wr_data;
   end
   // asynchronous read, same cycle as the address
   assign mem_rd_data = ram[mem_rd_addr];
endmodule

/* File: tb/rbm_ring_manager_props.sv */
`timescale 1ns/100ps
`include "rbm_cfg.svh"
module rbm_ring_manager_props (
   input wire logic               ref_clk,
   input wire logic               rst,
   input wire logic [`RBM_AW-1:0] rx_ring_start,
   input wire logic [`RBM_AW-1:0] rx_ring_end,
   input wire logic               pointer_auto_advance,
   input wire logic               buffer_read_command,
   input wire logic               buffer_read_pointer_wr,
   input wire logic               rx_release_pointer_high_wr,
   input wire logic [7:0]         rx_release_wdata,
   input wire logic               rx_error_clear,
   input wire logic               rx_error_int_enable,
   input wire logic               packet_int_enable,
   input wire logic [7:0]         mem_rd_data,
   input wire logic [7:0]         buffer_read_data,
   input wire logic [`RBM_AW-1:0] buffer_read_pointer,
   input wire logic [7:0]         rx_release_pointer_low,
   input wire logic [7:0]         rx_release_pointer_high,
   input wire logic [7:0]         pending_packet_count,
   input wire logic               packet_pending_flag,
   input wire logic               rx_error_flag,
   input wire logic               irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [7:0] wd_q;
   always_ff @(posedge ref_clk) wd_q <= rx_release_wdata;
   a_release_hold: assert property (!rx_release_pointer_high_wr |=>
      $stable({rx_release_pointer_high, rx_release_pointer_low})) else $error("release moved");
   a_release_load: assert property (rx_release_pointer_high_wr |=>
      rx_release_pointer_high == {3'h0, wd_q[4:0]}) else $error("release high wrong");
   a_flag_count: assert property (
      packet_pending_flag == (pending_packet_count != 8'h00)) else $error("flag vs count");
   a_no_underflow: assert property (pending_packet_count == 8'h00 |=>
      pending_packet_count != 8'hff) else $error("count underflow");
   a_no_overflow: assert property (pending_packet_count == 8'hff |=>
      pending_packet_count != 8'h00) else $error("count overflow");
   a_irq_gating: assert property (irq == (rx_error_flag && rx_error_int_enable ||
      packet_pending_flag && packet_int_enable)) else $error("irq gating");
   a_error_sticky: assert property (rx_error_flag && !rx_error_clear |=>
      rx_error_flag) else $error("error flag lost");
   a_read_wrap: assert property (buffer_read_command && pointer_auto_advance &&
      !buffer_read_pointer_wr && buffer_read_pointer == rx_ring_end |=>
      buffer_read_pointer == rx_ring_start) else $error("read pointer wrap");
   a_read_capture: assert property (buffer_read_command && !buffer_read_pointer_wr |=>
      buffer_read_data == $past(mem_rd_data)) else $error("read data");
   cover property (rx_error_flag && irq);
   cover property (pending_packet_count == 8'hff);
   cover property (buffer_read_command && buffer_read_pointer == rx_ring_end);
endmodule
bind rbm_ring_manager rbm_ring_manager_props u_props (.ref_clk, .rst, .rx_ring_start,
   .rx_ring_end, .pointer_auto_advance, .buffer_read_command, .buffer_read_pointer_wr,
   .rx_release_pointer_high_wr, .rx_release_wdata, .rx_error_clear, .rx_error_int_enable,
   .packet_int_enable, .mem_rd_data, .buffer_read_data, .buffer_read_pointer,
   .rx_release_pointer_low, .rx_release_pointer_high, .pending_packet_count,
   .packet_pending_flag, .rx_error_flag, .irq);

/* File: tb/tb_rbm_ring_manager.sv */
`timescale 1ns/100ps
`include "rbm_cfg.svh"
module tb_rbm_ring_manager;
   logic ref_clk = 1'h0, rst = 1'h1, link_clk = 1'h0, link_valid = 1'h0, rx_enable = 1'h0;
   logic pointer_auto_advance = 1'h1, buffer_read_command = 1'h0, buffer_read_pointer_wr = 1'h0;
   logic rx_release_pointer_low_wr = 1'h0, rx_release_pointer_high_wr = 1'h0;
   logic packet_decrement_cmd = 1'h0, rx_error_clear = 1'h0, rx_error_int_enable = 1'h0;
   logic packet_int_enable = 1'h1, mem_we, packet_pending_flag, rx_error_flag, irq;
   logic [7:0] link_data = 8'h00, rx_release_wdata = 8'h00, mem_rd_data, mem_wr_data;
   logic [7:0] buffer_read_data, rx_release_pointer_low, rx_release_pointer_high;
   logic [7:0] pending_packet_count;
   logic [`RBM_FLAG_W-1:0] link_flags = 28'h0;
   logic [`RBM_AW-1:0] rx_ring_start = 13'h0010, rx_ring_end = 13'h003f;
   logic [`RBM_AW-1:0] buffer_read_pointer_wdata = 13'h0000, mem_rd_addr, mem_wr_addr;
   logic [`RBM_AW-1:0] buffer_read_pointer, rx_hw_write_pointer;
   logic [31:0] seed = 32'h00010c50;
   int wp, ps, len, rel, abt, num_errors, n_tests, mem [8192];
   always #10 ref_clk = ~ref_clk;
   rbm_ring_manager dut (.ref_clk, .rst, .link_clk, .link_valid, .link_data, .link_flags,
      .rx_enable, .rx_ring_start, .rx_ring_end, .pointer_auto_advance, .buffer_read_command,
      .buffer_read_pointer_wr, .buffer_read_pointer_wdata, .rx_release_pointer_low_wr,
      .rx_release_pointer_high_wr, .rx_release_wdata, .packet_decrement_cmd, .rx_error_clear,
      .rx_error_int_enable, .packet_int_enable, .mem_rd_data, .mem_rd_addr, .mem_we,
      .mem_wr_addr, .mem_wr_data, .buffer_read_data, .buffer_read_pointer,
      .rx_release_pointer_low, .rx_release_pointer_high, .rx_hw_write_pointer,
      .pending_packet_count, .packet_pending_flag, .rx_error_flag, .irq);
   rbm_sram_model u_ram (.ref_clk, .mem_we, .mem_wr_addr, .mem_wr_data, .mem_rd_addr,
      .mem_rd_data);
   function int adv(int a);
      return (a == rx_ring_end) ? rx_ring_start : a + 1;
   endfunction
   function logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task close_out;
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic frame(int n, logic [31:0] fl, bit ok);
      int a, e;
      logic [27:0] f;
      logic [31:0] st, r;
      logic [7:0] h[$];
      f = {fl[27:16], 4'h0, fl[11:0]};
      st = {1'h0, f[27], f[24] & f[26], f[24] & f[25], f[24], f[23], f[22], f[21],
            ~f[20] & ~f[19], f[15:0] > `RBM_TYPE_MAX, f[18] & (f[15:0] <= `RBM_TYPE_MAX),
            f[20], 1'h0, f[16], 1'h0, f[17] | (abt != 0), n[15:0]};
      e = wp + 6 + n;
      e = e + (e & 1);
      if (e > rx_ring_end) e = e - (rx_ring_end - rx_ring_start + 1);
      h = {e[7:0], e[15:8], n[7:0], n[15:8], st[23:16], st[31:24]};
      link_flags = f;
      link_valid = 1'h1;
      repeat (n) begin
         r = rnd();
         h.push_back(r[7:0]);
         link_data = r[7:0];
         #80 link_clk = 1'h1;
         #80 link_clk = 1'h0;
      end
      link_valid = 1'h0;
      repeat (20) @(negedge ref_clk);
      if (ok) begin
         a = wp;
         foreach (h[i]) begin
            mem[a] = h[i];
            a = adv(a);
         end
         ps = wp;
         len = n + 6;
         wp = e;
         abt = 0;
      end else abt = 1;
      chk("wr_ptr", rx_hw_write_pointer, wp);
   endtask
   task automatic rdback;
      int a;
      a = ps;
      buffer_read_pointer_wdata = ps[12:0];
      buffer_read_pointer_wr = 1'h1;
      @(negedge ref_clk);
      buffer_read_pointer_wr = 1'h0;
      buffer_read_command = 1'h1;
      repeat (len) begin
         @(negedge ref_clk);
         chk("rd_data", buffer_read_data, mem[a]);
         a = adv(a);
      end
      buffer_read_command = 1'h0;
   endtask
   task automatic relw(int p);
      rx_release_wdata = p[7:0];
      rx_release_pointer_low_wr = 1'h1;
      @(negedge ref_clk);
      rx_release_wdata = {3'h0, p[12:8]};
      rx_release_pointer_low_wr = 1'h0;
      rx_release_pointer_high_wr = 1'h1;
      chk("rel_hold", {rx_release_pointer_high, rx_release_pointer_low}, rel);
      @(negedge ref_clk);
      rx_release_pointer_high_wr = 1'h0;
      rel = p;
      chk("release", {rx_release_pointer_high, rx_release_pointer_low}, rel);
   endtask
   task dec;
      packet_decrement_cmd = 1'h1;
      @(negedge ref_clk);
      packet_decrement_cmd = 1'h0;
      @(negedge ref_clk);
   endtask
   initial begin
      repeat (12) @(negedge ref_clk);
      rst = 1'h0;
      repeat (4) @(negedge ref_clk);
      rx_enable = 1'h1;
      wp = rx_ring_start;
      relw(rx_ring_start);
      // three frames, the last one crossing the ring end
      for (int i = 0; i < 3; i++) begin
         frame(7 + 7 * i, rnd(), 1'b1);
         chk("count", pending_packet_count, 1);
         chk("irq", irq, 1);
         rdback();
         relw(wp);
         dec();
         chk("flag", {pending_packet_count, packet_pending_flag}, 0);
      end
      rx_error_int_enable = 1'h1;
      frame(50, rnd(), 1'b0);
      chk("err", {rx_error_flag, irq, pending_packet_count}, 32'h300);
      rx_error_clear = 1'h1;
      @(negedge ref_clk);
      rx_error_clear = 1'h0;
      @(negedge ref_clk);
      chk("err", rx_error_flag, 0);
      frame(9, rnd(), 1'b1);
      rdback();
      relw(wp);
      dec();
      for (int i = 0; i < 255; i++) begin
         frame(1, rnd(), 1'b1);
         relw(wp);
      end
      frame(1, rnd(), 1'b0);
      chk("sat", {rx_error_flag, pending_packet_count}, 32'h1ff);
      repeat (256) dec();
      chk("drain", {pending_packet_count, packet_pending_flag}, 0);
      close_out();
   end
   initial begin
      #1000000;
      num_errors++;
      close_out();
   end
endmodule
